// ### core/acc_pkg.sv
package acc_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'h34;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h35;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h36;
  localparam int ADDR_W = 8;

  // ==========================================================
  // Field positions
  localparam int CSR_DONE_BIT = 7;
  localparam int CSR_SPEED_BIT = 6;
  localparam int CSR_ON_BIT = 5;
  localparam int CSR_CH_LSB = 0;
  localparam int LOW_SLOW_BIT = 3;
  localparam int RES_W = 10;
  localparam int CH_W = 3;
  localparam int NUM_CH = 5;

  // ==========================================================
  // Reset values and saturation codes
  localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [RES_W-1:0] RESULT_FULL = 10'h3ff;
  localparam logic [RES_W-1:0] RESULT_ZERO = 10'h000;
  localparam logic [CH_W-1:0] CH_RESET = 3'h0;

  // ==========================================================
  // Timing in converter clock ticks
  localparam logic [2:0] SAMPLE_TICKS = 3'h2;
  // Index of the last of the 8 approximation ticks
  localparam logic [2:0] SAR_CYCLES = 3'h7;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  typedef enum logic [1:0] {
    ACC_OFF,
    ACC_SAMPLE,
    ACC_HOLD
  } acc_phase_type;

  typedef struct packed {
    acc_phase_type phase;
    logic speed;
    logic conv_on;
    logic [CH_W-1:0] ch;
    logic slow;
    logic done;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] sar;
    logic [1:0] div;
    logic [2:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_CH-1:0] analog_sel;
    logic sample_on;
    logic [7:0] dac_code;
    logic [NUM_CH-1:0] pin_level;
  } acc_state_type;

endpackage

// ### core/acc_ctrl.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// (RL1) Each conversion yields a 10-bit result in a readable register pair.
// (RL2) One of five analog inputs is routed through the input multiplexer.
// (RL3) Input above high reference saturates to FFh high, 03h low, no overflow.
// (RL4) Input below low reference gives all-zero high and low results.
// (RL5) Result is monotonic in the input voltage.
// (RL6) Sampling, then hold of 8 approximation cycles, capacitor isolated.
// (RL7) While on, sample and hold phases repeat back to back.
// (RL8) Three-bit channel field in control/status picks the converted input.
// (RL9) Setting converter_on starts continuous conversion of the channel.
// (RL10) Each completed conversion sets done flag and stores the result.
// (RL11) Reading the high result register clears the done flag.
// (RL12) Software polls done, reads low, then high for full result.
// (RL13) Analog pins stay readable through the digital input path.
// (RL14) Channel codes 000 to 100 map to analog inputs zero to four.
// (RL15) Control/status write while on aborts, clears done, restarts.
// (RL16) High register holds bits 9:2, low register bits 1:0.
// (RL17) Converter clock: CPU/2, CPU, or CPU/4 when slow is set.
// (RL18) While off, no conversions run and done is never set.
module acc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_above,
  input wire logic [1:0] fine_code,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic [acc_pkg::NUM_CH-1:0] pin_digital,
  output logic [acc_pkg::NUM_CH-1:0] analog_sel,
  output logic sample_on,
  output logic [7:0] dac_code,
  output logic [acc_pkg::NUM_CH-1:0] pin_level
);

  // ==========================================================
  // Helpers
  function automatic logic [acc_pkg::NUM_CH-1:0] ch_onehot(
    input logic [acc_pkg::CH_W-1:0] code
  );
    logic [acc_pkg::NUM_CH-1:0] oh;
    oh = '0;
    if (code < 3'h5) begin
      oh[code] = 1'b1;
    end
    return oh;
  endfunction

  function automatic logic is_reg(
    input logic [acc_pkg::ADDR_W-1:0] a,
    input logic [7:0] idx
  );
    return a == acc_pkg::ADDR_W'({idx[5:0], 2'h0});
  endfunction

  acc_pkg::acc_state_type state_reg;
  acc_pkg::acc_state_type state_next;

  logic tick;
  logic apb_setup;
  logic apb_done;
  logic csr_write;
  logic hit;
  logic [31:0] rd;

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    apb_setup = psel && !penable;
    apb_done = psel && penable && state_reg.pready;
    csr_write = apb_done && pwrite && pstrb[0] &&
      is_reg(paddr, acc_pkg::IDX_CONTROL_STATUS);
    hit = is_reg(paddr, acc_pkg::IDX_CONTROL_STATUS) ||
      is_reg(paddr, acc_pkg::IDX_RESULT_HIGH) ||
      is_reg(paddr, acc_pkg::IDX_RESULT_LOW);

    // Converter clock divider
    if (state_reg.slow) begin
      tick = state_reg.div == acc_pkg::DIV4_LAST; // RL17
    end else if (state_reg.speed) begin
      tick = 1'b1; // RL17
    end else begin
      tick = state_reg.div[0]; // RL17
    end
    state_next.div = state_reg.div + 2'h1;

    // Read data, captured in the setup cycle
    rd = 32'h0000_0000;
    if (is_reg(paddr, acc_pkg::IDX_CONTROL_STATUS)) begin
      rd[acc_pkg::CSR_DONE_BIT] = state_reg.done;
      rd[acc_pkg::CSR_SPEED_BIT] = state_reg.speed;
      rd[acc_pkg::CSR_ON_BIT] = state_reg.conv_on;
      rd[acc_pkg::CSR_CH_LSB +: acc_pkg::CH_W] = state_reg.ch;
    end else if (is_reg(paddr, acc_pkg::IDX_RESULT_HIGH)) begin
      rd[7:0] = state_reg.result[9:2]; // RL16
    end else if (is_reg(paddr, acc_pkg::IDX_RESULT_LOW)) begin
      rd[acc_pkg::LOW_SLOW_BIT] = state_reg.slow;
      rd[1:0] = state_reg.result[1:0]; // RL16
    end
    if (apb_setup) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata = pwrite ? 32'h0000_0000 : rd;
    end else if (apb_done) begin
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
    end

    // Register writes
    if (csr_write) begin
      state_next.speed = pwdata[acc_pkg::CSR_SPEED_BIT];
      state_next.conv_on = pwdata[acc_pkg::CSR_ON_BIT]; // RL9
      state_next.ch = pwdata[acc_pkg::CSR_CH_LSB +: acc_pkg::CH_W]; // RL8
    end
    if (apb_done && pwrite && pstrb[0] &&
        is_reg(paddr, acc_pkg::IDX_RESULT_LOW)) begin
      state_next.slow = pwdata[acc_pkg::LOW_SLOW_BIT];
    end

    // Done flag cleared by a high result read
    if (apb_done && !pwrite &&
        is_reg(paddr, acc_pkg::IDX_RESULT_HIGH)) begin
      state_next.done = 1'b0; // RL11
    end

    // Conversion sequencer
    unique case (state_reg.phase)
      acc_pkg::ACC_OFF: begin
        state_next.sample_on = 1'b0; // RL18
        if (state_reg.conv_on) begin
          state_next.phase = acc_pkg::ACC_SAMPLE; // RL9
          state_next.cnt = 3'h0;
          state_next.sample_on = 1'b1;
        end
      end
      acc_pkg::ACC_SAMPLE: begin
        if (tick) begin
          state_next.cnt = state_reg.cnt + 3'h1;
          if (state_reg.cnt == acc_pkg::SAMPLE_TICKS - 3'h1) begin
            state_next.phase = acc_pkg::ACC_HOLD; // RL6
            state_next.sample_on = 1'b0; // RL6
            state_next.cnt = 3'h0;
            state_next.sar = 10'h200;
            state_next.dac_code = 8'h80;
          end
        end
      end
      acc_pkg::ACC_HOLD: begin
        if (tick) begin
          // One approximation cycle per tick, bits 9 down to 2
          // Four-bit index so bit 9 does not wrap
          state_next.sar[4'h9 - {1'b0, state_reg.cnt}] = comp_above; // RL5
          state_next.cnt = state_reg.cnt + 3'h1;
          if (state_reg.cnt != acc_pkg::SAR_CYCLES) begin
            state_next.sar[4'h8 - {1'b0, state_reg.cnt}] = 1'b1;
            state_next.dac_code = state_next.sar[9:2];
          end else begin
            if (over_range) begin
              state_next.result = acc_pkg::RESULT_FULL; // RL3
            end else if (under_range) begin
              state_next.result = acc_pkg::RESULT_ZERO; // RL4
            end else begin
              state_next.result = {state_next.sar[9:2], fine_code}; // RL1
            end
            state_next.done = 1'b1; // RL10
            state_next.phase = acc_pkg::ACC_SAMPLE; // RL7
            state_next.sample_on = 1'b1; // RL7
            state_next.cnt = 3'h0;
          end
        end
      end
    endcase

    // Abort and restart on control write, or stop when switched off
    if (csr_write && state_reg.conv_on) begin
      state_next.done = 1'b0; // RL15
      state_next.phase = acc_pkg::ACC_SAMPLE; // RL15
      state_next.sample_on = 1'b1;
      state_next.cnt = 3'h0;
    end
    if (!state_next.conv_on) begin
      state_next.phase = acc_pkg::ACC_OFF; // RL18
      state_next.sample_on = 1'b0;
      state_next.cnt = 3'h0;
    end
    if (csr_write && state_reg.conv_on && !state_next.conv_on) begin
      state_next.done = 1'b0; // RL15
    end

    state_next.analog_sel = ch_onehot(state_next.ch); // RL2 RL14
    state_next.pin_level = pin_digital; // RL13
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{phase: acc_pkg::ACC_OFF, speed: 1'b0, conv_on: 1'b0,
        ch: acc_pkg::CH_RESET, slow: 1'b0, done: 1'b0,
        result: acc_pkg::RESULT_RESET, sar: 10'h000, div: 2'h0,
        cnt: 3'h0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
        analog_sel: 5'h01, sample_on: 1'b0, dac_code: 8'h00,
        pin_level: 5'h00};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign analog_sel = state_reg.analog_sel;
  assign sample_on = state_reg.sample_on;
  assign dac_code = state_reg.dac_code;
  assign pin_level = state_reg.pin_level;

endmodule

// ### bench/acc_chk.sv
`timescale 1ns/1ps
// ==========
// Port checker
module acc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [acc_pkg::NUM_CH-1:0] pin_digital,
  input wire logic [acc_pkg::NUM_CH-1:0] pin_level,
  input wire logic [acc_pkg::NUM_CH-1:0] analog_sel,
  input wire logic sample_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable && clk_en |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err;
    pready |-> pslverr == !(paddr inside {8'hd0, 8'hd4, 8'hd8});
  endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_hi; pready |-> prdata[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_low;
    pready && !pwrite && paddr == 8'hd8 |->
      prdata[7:4] == 4'h0 && !prdata[2];
  endproperty
  a_low: assert property (p_low) else $error("low reserved set");
  property p_sel; sample_on |-> $onehot(analog_sel); endproperty
  a_sel: assert property (p_sel) else $error("no channel");
  property p_smp;
    $rose(sample_on) |-> sample_on[*2] or ##[0:1] (psel && pwrite);
  endproperty
  a_smp: assert property (p_smp) else $error("short sample");
  property p_iso;
    $fell(sample_on) |-> !sample_on[*8] or ##[0:7] (psel && pwrite);
  endproperty
  a_iso: assert property (p_iso) else $error("short hold");
  property p_rep;
    $fell(sample_on) && !$past(psel && pwrite) |->
      ##[1:48] (sample_on || (psel && pwrite));
  endproperty
  a_rep: assert property (p_rep) else $error("no repeat");
  property p_pin; clk_en |=> pin_level == $past(pin_digital); endproperty
  a_pin: assert property (p_pin) else $error("pin copy");
endmodule

bind acc_ctrl acc_chk acc_chk_i (.*);

// ### bench/acc_analog.sv
`timescale 1ns/1ps
// ==========
// Analog side with sample capacitor
module acc_analog (
  input wire logic pclk,
  input wire logic [4:0] analog_sel,
  input wire logic sample_on,
  input wire logic [7:0] dac_code,
  input wire logic [59:0] vin_all,
  output logic comp_above,
  output logic [1:0] fine_code,
  output logic over_range,
  output logic under_range
);
  logic signed [11:0] held_reg = 12'sd0;
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 5; i++) begin
      if (sample_on && analog_sel[i]) begin
        held_reg <= vin_all[i*12 +: 12];
      end
    end
  end
  assign over_range = held_reg > 12'sd1023;
  assign under_range = held_reg < 12'sd0;
  assign comp_above = held_reg[9:2] >= dac_code;
  assign fine_code = held_reg[1:0];
endmodule

// ### bench/adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
  // ==========
  // Signals and instances
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, dac_code, rd;
  logic [31:0] pwdata = 32'h0, prdata, s = 32'd9821;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, comp_above, over_range, under_range, sample_on;
  logic [1:0] fine_code;
  logic [4:0] pin_digital = 5'h00, analog_sel, pin_level;
  logic [59:0] vin_all = 60'h0;
  logic [16:0] expq[$];
  int bad_count = 0, total_checks = 0;
  always #10 pclk = ~pclk;
  acc_ctrl acc_ctrl_i (.*);
  acc_analog acc_analog_i (.*);
  always @(posedge pclk) pin_digital <= pin_digital ^ s[6:2];
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // ==========
  // Bus tasks
  task automatic xfer(input logic w, input logic [7:0] a, d, m, input logic e);
    int n;
    logic [31:0] r;
    n = 0;
    r = xs();
    expq.push_back({m, e, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) bad_count++;
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd8(input logic [7:0] a, d, m);
    xfer(1'b0, a, d, m, 1'b0);
  endtask
  task automatic wr8(input logic [7:0] a, d);
    xfer(1'b1, a, d, 8'h00, 1'b0);
  endtask
  task automatic poll();
    rd = 8'h00;
    for (int k = 0; k < 40 && !rd[7]; k++) rd8(8'hd0, 8'h00, 8'h00);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin : mon
    logic [16:0] x;
    if (pready === 1'b1) begin
      x = expq.pop_front();
      total_checks++;
      if ((((prdata[7:0] ^ x[7:0]) & x[16:9]) !== 8'h00) ||
          pslverr !== x[8]) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time,
          {pslverr, prdata[7:0]}, x[8:0]);
      end
    end
  end
  initial begin
    repeat (6000) @(posedge pclk);
    bad_count++;
    conclude();
  end
  // ==========
  // Tests
  initial begin
    logic signed [11:0] v;
    logic [31:0] r;
    logic [9:0] e;
    logic [7:0] c;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd8(8'hd8, 8'h00, 8'hff);
    wr8(8'hd4, 8'h5a);
    xfer(1'b0, 8'hdc, 8'h00, 8'hff, 1'b1);
    repeat (100) @(posedge pclk);
    rd8(8'hd4, 8'h00, 8'hff);
    rd8(8'hd0, 8'h00, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      r = xs();
      v = i == 3 ? 12'sd1500 : i == 4 ? -12'sd7 : {2'b00, r[9:0]};
      e = v > 12'sd1023 ? 10'h3ff : v < 12'sd0 ? 10'h000 : v[9:0];
      vin_all[i*12 +: 12] <= v;
      c = {1'b0, i[1], 3'b100, i[2:0]};
      wr8(8'hd8, {4'h0, !i[0], 3'h0});
      wr8(8'hd0, c | 8'h18);
      poll();
      rd8(8'hd0, 8'h80, 8'h80);
      rd8(8'hd8, {4'h0, !i[0], 1'b0, e[1:0]}, 8'hff);
      rd8(8'hd4, e[9:2], 8'hff);
      rd8(8'hd0, c, i[0] ? 8'h7f : 8'hff);
      $display("test channel %0d done", i);
    end
    poll();
    wr8(8'hd0, 8'h24);
    rd8(8'hd0, 8'h24, 8'hff);
    wr8(8'hd0, 8'h04);
    repeat (200) @(posedge pclk);
    rd8(8'hd0, 8'h04, 8'hff);
    $display("test abort and off done");
    conclude();
  end
endmodule
